/* File: rtl/mle_pkg.sv */
/*
  Package for the move, logic and rotate execution block: operation codes,
  widths, reset values and cycle counts.
  Assumes the program sequencer decodes instructions into these codes.
*/
package mle_pkg;
  localparam int DATA_W = 8;
  localparam int PC_W = 11;
  localparam int ADDR_W = 7;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [10:0] PC_RST = 11'h000;
  localparam logic [10:0] PC_STEP = 11'h001;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [6:0] PC_LOW_ADDR = 7'h06;
  localparam int MSB = 7;
  localparam int LSB = 0;
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;

  typedef enum logic [4:0] {
    OP_NOP,
    OP_INC,
    OP_INC_ACC,
    OP_JMP,
    OP_CALL,
    OP_MOV_A_M,
    OP_MOV_A_X,
    OP_MOV_M_A,
    OP_OR_A_M,
    OP_OR_A_X,
    OP_OR_M,
    OP_RET,
    OP_RET_A_X,
    OP_IRET,
    OP_RL,
    OP_RL_ACC,
    OP_RL_CY,
    OP_RL_CY_ACC,
    OP_RR,
    OP_RR_ACC,
    OP_RR_CY,
    OP_RR_CY_ACC
  } mle_op_t;
endpackage

/* File: rtl/mle_exec.sv */
/*
  Execution unit for increment, jump, call, moves, OR, returns and rotates.
  Assumes one instruction offered per ready cycle, a single-port data memory
  with combinational read, and a stack supplied by the sequencer.
*/
`timescale 1ns/1ps

// Summary of operation
// - Memory increment writes byte plus one back to the same byte.
// - Increment to accumulator puts byte plus one in accumulator, sets zero.
// - Jump loads program counter from instruction, two cycles, no flags.
// - Move from memory copies byte to accumulator, no flags.
// - Move immediate loads byte into accumulator, no flags.
// - Move to memory writes accumulator into byte, no flags.
// - No-operation changes nothing except advancing the program counter.
// - OR into accumulator, with memory or immediate, updates zero only.
// - OR to memory writes accumulator OR byte back, updates zero.
// - Return pops program counter from stack, flags unchanged.
// - Return with value restores counter and loads immediate to accumulator.
// - Interrupt return restores counter, sets global enable, pending first.
// - Rotate left writes byte back with bit 7 into bit 0.
// - Rotate left to accumulator, memory unchanged, no flags.
// - Rotate left through carry writes memory, carry from old bit 7.
// - Same nine-bit left rotation into accumulator, carry updated.
// - Rotate right writes byte back with bit 0 into bit 7.
// - Rotate right to accumulator, no carry, no flags.
// - Rotate right through carry writes memory, carry from old bit 0.
// - Same nine-bit right rotation into accumulator, carry updated.
// - Any write to the program counter low byte takes two cycles.
// - Call pushes program counter plus one onto the stack.
module mle_exec
  import mle_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic op_valid,
  input wire mle_op_t op_code,
  input wire logic [ADDR_W-1:0] op_addr,
  input wire logic [DATA_W-1:0] op_imm,
  input wire logic [PC_W-1:0] op_target,
  input wire logic [DATA_W-1:0] mem_rdata,
  input wire logic [PC_W-1:0] stack_top,
  input wire logic irq_pending,
  output logic op_ready,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [DATA_W-1:0] mem_wdata,
  output logic mem_we,
  output logic stack_push,
  output logic stack_pop,
  output logic [PC_W-1:0] stack_wdata,
  output logic irq_take,
  output logic [PC_W-1:0] pc,
  output logic [DATA_W-1:0] acc,
  output logic zero_flag,
  output logic carry_flag,
  output logic global_interrupt_enable
);

  logic rst_meta_reg, rst_sync_reg;
  logic [DATA_W-1:0] res;
  logic to_acc, to_mem, set_z, set_c, new_c, flow, load_pc;
  logic [PC_W-1:0] pc_next;
  logic take;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  function automatic logic [DATA_W-1:0] rot_left(input logic [7:0] v,
                                                 input logic b0);
    rot_left = {v[MSB-1:LSB], b0};
  endfunction

  function automatic logic [DATA_W-1:0] rot_right(input logic [7:0] v,
                                                  input logic b7);
    rot_right = {b7, v[MSB:LSB+1]};
  endfunction

  assign take = op_valid && op_ready;

  // Result, destination and flag decode
  always_comb begin
    res = BYTE_ZERO;
    to_acc = 1'b0;
    to_mem = 1'b0;
    set_z = 1'b0;
    set_c = 1'b0;
    new_c = carry_flag;
    flow = 1'b0;
    pc_next = pc + PC_STEP;
    case (op_code)
      OP_NOP: ;
      OP_INC: begin
        res = mem_rdata + BYTE_ONE;
        to_mem = 1'b1;
        set_z = 1'b1;
      end
      OP_INC_ACC: begin
        res = mem_rdata + BYTE_ONE;
        to_acc = 1'b1;
        set_z = 1'b1;
      end
      OP_JMP, OP_CALL: begin
        pc_next = op_target;
        flow = 1'b1;
      end
      OP_MOV_A_M: begin
        res = mem_rdata;
        to_acc = 1'b1;
      end
      OP_MOV_A_X, OP_RET_A_X: begin
        res = op_imm;
        to_acc = 1'b1;
      end
      OP_MOV_M_A: begin
        res = acc;
        to_mem = 1'b1;
      end
      OP_OR_A_M: begin
        res = acc | mem_rdata;
        to_acc = 1'b1;
        set_z = 1'b1;
      end
      OP_OR_A_X: begin
        res = acc | op_imm;
        to_acc = 1'b1;
        set_z = 1'b1;
      end
      OP_OR_M: begin
        res = acc | mem_rdata;
        to_mem = 1'b1;
        set_z = 1'b1;
      end
      OP_RL, OP_RL_ACC: begin
        res = rot_left(mem_rdata, mem_rdata[MSB]);
        to_mem = (op_code == OP_RL);
        to_acc = (op_code == OP_RL_ACC);
      end
      OP_RL_CY, OP_RL_CY_ACC: begin
        res = rot_left(mem_rdata, carry_flag);
        new_c = mem_rdata[MSB];
        set_c = 1'b1;
        to_mem = (op_code == OP_RL_CY);
        to_acc = (op_code == OP_RL_CY_ACC);
      end
      OP_RR, OP_RR_ACC: begin
        res = rot_right(mem_rdata, mem_rdata[LSB]);
        to_mem = (op_code == OP_RR);
        to_acc = (op_code == OP_RR_ACC);
      end
      OP_RR_CY, OP_RR_CY_ACC: begin
        res = rot_right(mem_rdata, carry_flag);
        new_c = mem_rdata[LSB];
        set_c = 1'b1;
        to_mem = (op_code == OP_RR_CY);
        to_acc = (op_code == OP_RR_CY_ACC);
      end
      default: ;
    endcase
    if (op_code == OP_RET || op_code == OP_RET_A_X || op_code == OP_IRET) begin
      pc_next = stack_top;
      flow = 1'b1;
    end
    // Memory write to the counter low byte redirects flow
    if (to_mem && op_addr == PC_LOW_ADDR) begin
      pc_next = {pc[PC_W-1:DATA_W], res};
      flow = 1'b1;
    end
    load_pc = flow;
  end

  assign mem_addr = op_addr;

  // Dummy cycle after any flow change
  always_ff @(posedge clock or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      op_ready <= 1'b0;
    end else begin
      op_ready <= !(take && load_pc);
    end
  end

  always_ff @(posedge clock or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      pc <= PC_RST;
    end else if (take) begin
      pc <= pc_next;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      acc <= ACC_RST;
      zero_flag <= 1'b0;
      carry_flag <= 1'b0;
    end else if (take) begin
      if (to_acc) begin
        acc <= res;
      end
      if (set_z) begin
        zero_flag <= (res == BYTE_ZERO);
      end
      if (set_c) begin
        carry_flag <= new_c;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      mem_we <= 1'b0;
      mem_wdata <= BYTE_ZERO;
      stack_push <= 1'b0;
      stack_pop <= 1'b0;
      stack_wdata <= PC_RST;
    end else begin
      mem_we <= take && to_mem;
      mem_wdata <= res;
      stack_push <= take && op_code == OP_CALL;
      stack_wdata <= pc + PC_STEP;
      stack_pop <= take && (op_code == OP_RET || op_code == OP_RET_A_X
                            || op_code == OP_IRET);
    end
  end

  // Interrupt return re-enables; a pending request is served at once
  always_ff @(posedge clock or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      global_interrupt_enable <= 1'b0;
      irq_take <= 1'b0;
    end else begin
      irq_take <= take && op_code == OP_IRET && irq_pending;
      if (take && op_code == OP_IRET) begin
        global_interrupt_enable <= 1'b1;
      end
    end
  end

  chk_jump_dummy_cycle: assert property (
    @(posedge clock) disable iff (!rst_sync_reg)
    (take && op_code == OP_JMP) |=> !op_ready ##1 op_ready)
    else $error("jump did not insert one dummy cycle");

  chk_jump_pc_load: assert property (
    @(posedge clock) disable iff (!rst_sync_reg)
    (take && op_code == OP_JMP) |=> pc == $past(op_target)
      && zero_flag == $past(zero_flag) && carry_flag == $past(carry_flag))
    else $error("jump target or flags wrong");

  chk_inc_acc_value: assert property (
    @(posedge clock) disable iff (!rst_sync_reg)
    (take && op_code == OP_INC_ACC) |=>
      acc == $past(mem_rdata) + BYTE_ONE && !mem_we
      && zero_flag == (acc == BYTE_ZERO))
    else $error("increment to accumulator wrong");

  chk_inc_mem_write: assert property (
    @(posedge clock) disable iff (!rst_sync_reg)
    (take && op_code == OP_INC) |=>
      mem_we && mem_wdata == $past(mem_rdata) + BYTE_ONE)
    else $error("memory increment wrong");

  chk_mov_no_flags: assert property (
    @(posedge clock) disable iff (!rst_sync_reg)
    (take && op_code == OP_MOV_A_M) |=> acc == $past(mem_rdata)
      && $stable(zero_flag) && $stable(carry_flag))
    else $error("move from memory wrong");

  chk_left_rot_carry: assert property (
    @(posedge clock) disable iff (!rst_sync_reg)
    (take && op_code == OP_RL_CY_ACC) |=>
      carry_flag == $past(mem_rdata[MSB])
      && acc == {$past(mem_rdata[MSB-1:LSB]), $past(carry_flag)})
    else $error("left rotate through carry wrong");

  chk_right_rot_carry: assert property (
    @(posedge clock) disable iff (!rst_sync_reg)
    (take && op_code == OP_RR_CY_ACC) |=>
      carry_flag == $past(mem_rdata[LSB])
      && acc == {$past(carry_flag), $past(mem_rdata[MSB:LSB+1])})
    else $error("right rotate through carry wrong");

  chk_or_mem_zero: assert property (
    @(posedge clock) disable iff (!rst_sync_reg)
    (take && op_code == OP_OR_M) |=> mem_we
      && mem_wdata == ($past(acc) | $past(mem_rdata))
      && zero_flag == (mem_wdata == BYTE_ZERO))
    else $error("OR to memory wrong");

  chk_iret_enable: assert property (
    @(posedge clock) disable iff (!rst_sync_reg)
    (take && op_code == OP_IRET) |=> global_interrupt_enable && stack_pop
      && pc == $past(stack_top) && !op_ready)
    else $error("interrupt return wrong");

  chk_call_push: assert property (
    @(posedge clock) disable iff (!rst_sync_reg)
    (take && op_code == OP_CALL) |=> stack_push
      && stack_wdata == $past(pc) + PC_STEP)
    else $error("call push value wrong");

  chk_single_cycle: assert property (
    @(posedge clock) disable iff (!rst_sync_reg)
    (take && !load_pc) |=> op_ready)
    else $error("simple instruction stalled");

  chk_rot_left_mem: assert property (
    @(posedge clock) disable iff (!rst_sync_reg)
    (take && op_code == OP_RL) |=> mem_we
      && mem_wdata == {$past(mem_rdata[MSB-1:LSB]), $past(mem_rdata[MSB])}
      && $stable(zero_flag) && $stable(carry_flag))
    else $error("left rotate to memory wrong");

  chk_rot_right_acc: assert property (
    @(posedge clock) disable iff (!rst_sync_reg)
    (take && op_code == OP_RR_ACC) |=> !mem_we
      && acc == {$past(mem_rdata[LSB]), $past(mem_rdata[MSB:LSB+1])}
      && $stable(zero_flag) && $stable(carry_flag))
    else $error("right rotate to accumulator wrong");

  chk_ret_value: assert property (
    @(posedge clock) disable iff (!rst_sync_reg)
    (take && op_code == OP_RET_A_X) |=> acc == $past(op_imm)
      && pc == $past(stack_top) && stack_pop && $stable(zero_flag))
    else $error("return with value wrong");

  chk_mov_to_mem: assert property (
    @(posedge clock) disable iff (!rst_sync_reg)
    (take && op_code == OP_MOV_M_A) |=> mem_we && mem_wdata == $past(acc)
      && $stable(zero_flag) && $stable(carry_flag))
    else $error("move to memory wrong");

  chk_pc_low_write: assert property (
    @(posedge clock) disable iff (!rst_sync_reg)
    (take && to_mem && op_addr == PC_LOW_ADDR) |=> !op_ready
      && pc[DATA_W-1:0] == $past(res)
      && pc[PC_W-1:DATA_W] == $past(pc[PC_W-1:DATA_W]))
    else $error("counter low byte write wrong");

  cov_jump: cover property (@(posedge clock) take && op_code == OP_JMP);
  cov_iret_pending: cover property (@(posedge clock)
    take && op_code == OP_IRET && irq_pending);
  cov_right_carry: cover property (@(posedge clock)
    take && op_code == OP_RR_CY);
  cov_pc_low_write: cover property (@(posedge clock)
    take && to_mem && op_addr == PC_LOW_ADDR);

endmodule // mle_exec

/* File: verification/mle_tb.sv */
/*
  Self-checking bench for the execution unit: a reference model driven by
  random and directed instructions, compared after every taken instruction.
  Assumes a combinational data memory and a stack top driven by the bench.
*/
`timescale 1ns/1ps
module testbench;
  import mle_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic op_valid = 1'b0;
  mle_op_t op_code = OP_NOP;
  logic [ADDR_W-1:0] op_addr = 7'h00;
  logic [DATA_W-1:0] op_imm = 8'h00;
  logic [PC_W-1:0] op_target = 11'h000;
  logic [PC_W-1:0] stack_top = 11'h000;
  logic irq_pending = 1'b0;
  logic [DATA_W-1:0] mem_rdata;
  logic op_ready, mem_we, stack_push, stack_pop, irq_take;
  logic [ADDR_W-1:0] mem_addr;
  logic [DATA_W-1:0] mem_wdata, acc;
  logic [PC_W-1:0] stack_wdata, pc;
  logic zero_flag, carry_flag, global_interrupt_enable;
  logic [DATA_W-1:0] mem [0:127];
  logic [DATA_W-1:0] m_acc;
  logic [PC_W-1:0] m_pc;
  logic m_z, m_c, m_gie;
  int error_cnt = 0;
  int n_tests = 0;
  int seed = 32'hbe18;

  assign mem_rdata = mem[mem_addr];
  always #25 clock = ~clock;

  mle_exec DUT (.clock(clock), .resetn(resetn), .op_valid(op_valid),
    .op_code(op_code), .op_addr(op_addr), .op_imm(op_imm),
    .op_target(op_target), .mem_rdata(mem_rdata), .stack_top(stack_top),
    .irq_pending(irq_pending), .op_ready(op_ready), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_we(mem_we), .stack_push(stack_push),
    .stack_pop(stack_pop), .stack_wdata(stack_wdata), .irq_take(irq_take),
    .pc(pc), .acc(acc), .zero_flag(zero_flag), .carry_flag(carry_flag),
    .global_interrupt_enable(global_interrupt_enable));

  task automatic close_out;
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic miss(input string what);
    error_cnt++;
    $display("unexpected at %0t: %s", $time, what);
  endtask

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp,
                          input string what);
    n_tests++;
    if (got !== exp) miss(what);
  endtask

  task automatic cmp_pc(input logic [10:0] got, input logic [10:0] exp,
                        input string what);
    n_tests++;
    if (got !== exp) miss(what);
  endtask

  task automatic cmp_bit(input logic got, input logic exp, input string what);
    n_tests++;
    if (got !== exp) miss(what);
  endtask

  // One instruction: wait for ready, drive, model, then check next cycle
  task automatic run_op(input mle_op_t code, input logic [6:0] a,
                        input logic hold);
    int w;
    logic [7:0] m, r, imm;
    logic [10:0] tgt, top, e_pc;
    logic irq, wr, zf, fl;
    w = 0;
    while (op_ready !== 1'b1 && w < 8) begin
      @(negedge clock);
      w++;
    end
    if (w == 8) miss("ready wait");
    imm = 8'($random(seed));
    tgt = 11'($random(seed));
    top = 11'($random(seed));
    irq = 1'($random(seed));
    op_code = code;
    op_addr = a;
    op_imm = imm;
    op_target = tgt;
    stack_top = top;
    irq_pending = irq;
    op_valid = 1'b1;
    m = mem[a];
    r = m;
    wr = 1'b0;
    zf = 1'b0;
    fl = 1'b0;
    e_pc = m_pc + PC_STEP;
    case (code)
      OP_INC: begin r = m + BYTE_ONE; wr = 1'b1; zf = 1'b1; end
      OP_INC_ACC: begin m_acc = m + BYTE_ONE; r = m_acc; zf = 1'b1; end
      OP_JMP, OP_CALL: begin e_pc = tgt; fl = 1'b1; end
      OP_MOV_A_M: m_acc = m;
      OP_MOV_A_X: m_acc = imm;
      OP_MOV_M_A: begin r = m_acc; wr = 1'b1; end
      OP_OR_A_M: begin m_acc = m_acc | m; r = m_acc; zf = 1'b1; end
      OP_OR_A_X: begin m_acc = m_acc | imm; r = m_acc; zf = 1'b1; end
      OP_OR_M: begin r = m_acc | m; wr = 1'b1; zf = 1'b1; end
      OP_RET: begin e_pc = top; fl = 1'b1; end
      OP_RET_A_X: begin e_pc = top; m_acc = imm; fl = 1'b1; end
      OP_IRET: begin e_pc = top; m_gie = 1'b1; fl = 1'b1; end
      OP_RL: begin r = {m[6:0], m[7]}; wr = 1'b1; end
      OP_RL_ACC: m_acc = {m[6:0], m[7]};
      OP_RL_CY: begin r = {m[6:0], m_c}; m_c = m[7]; wr = 1'b1; end
      OP_RL_CY_ACC: begin m_acc = {m[6:0], m_c}; m_c = m[7]; end
      OP_RR: begin r = {m[0], m[7:1]}; wr = 1'b1; end
      OP_RR_ACC: m_acc = {m[0], m[7:1]};
      OP_RR_CY: begin r = {m_c, m[7:1]}; m_c = m[0]; wr = 1'b1; end
      OP_RR_CY_ACC: begin m_acc = {m_c, m[7:1]}; m_c = m[0]; end
      default: ;
    endcase
    if (zf) m_z = (r == BYTE_ZERO);
    if (wr && a == PC_LOW_ADDR) begin
      e_pc = {m_pc[10:8], r};
      fl = 1'b1;
    end
    @(posedge clock);
    @(negedge clock);
    if (!hold) op_valid = 1'b0;
    cmp_byte(acc, m_acc, "acc");
    cmp_bit(zero_flag, m_z, "zero");
    cmp_bit(carry_flag, m_c, "carry");
    cmp_bit(global_interrupt_enable, m_gie, "enable");
    cmp_bit(mem_we, wr, "write strobe");
    if (wr) cmp_byte(mem_wdata, r, "write data");
    if (wr) cmp_byte({1'b0, mem_addr}, {1'b0, a}, "write addr");
    cmp_bit(op_ready, !fl, "ready");
    cmp_bit(stack_push, code == OP_CALL, "push");
    if (code == OP_CALL) cmp_pc(stack_wdata, m_pc + PC_STEP, "push");
    cmp_bit(stack_pop, code inside {OP_RET, OP_RET_A_X, OP_IRET}, "pop");
    cmp_bit(irq_take, code == OP_IRET && irq, "irq take");
    cmp_pc(pc, e_pc, "pc");
    if (wr && a == PC_LOW_ADDR) cmp_byte(pc[7:0], r, "pc low");
    m_pc = e_pc;
    if (wr) mem[a] = r;
    if (!hold) @(negedge clock);
  endtask

  initial begin
    #(50 * 20000);
    miss("watchdog");
    close_out;
  end

  initial begin
    mle_op_t code;
    logic [6:0] a;
    logic hold;
    for (int i = 0; i < 128; i++) mem[i] = 8'($random(seed));
    repeat (8) @(negedge clock);
    cmp_byte(acc, ACC_RST, "reset acc");
    cmp_pc(pc, PC_RST, "reset pc");
    cmp_bit(op_ready, 1'b0, "reset ready");
    resetn = 1'b1;
    m_acc = ACC_RST;
    m_pc = PC_RST;
    m_z = 1'b0;
    m_c = 1'b0;
    m_gie = 1'b0;
    // Every code once, then a random mix with back-to-back issue
    for (int i = 0; i < 600; i++) begin
      code = mle_op_t'(i < 22 ? i : {$random(seed)} % 22);
      a = 7'($random(seed));
      if (a == PC_LOW_ADDR) a = 7'h07;
      hold = 1'($random(seed)) && !(code inside {OP_INC, OP_MOV_M_A,
        OP_OR_M, OP_RL, OP_RL_CY, OP_RR, OP_RR_CY});
      run_op(code, a, hold);
    end
    run_op(OP_MOV_M_A, PC_LOW_ADDR, 1'b0);
    run_op(OP_INC, PC_LOW_ADDR, 1'b0);
    run_op(OP_NOP, 7'h10, 1'b0);
    close_out;
  end
endmodule // testbench
